// ===== include/exec_consts.svh
// Purpose: constants of the increment/decrement and literal execution unit
// Assumes: core clock of 25 MHz, four core clocks per instruction cycle
// Notes:   widths, timing counts, destination selects and reset values as macros
// How it works
// - decrement file: f minus one to w or file by dest, z updated
// - increment file: f plus one to w or file by dest, z updated
// - decrement-skip: f minus one to w or file, flags untouched
// - increment-skip: f plus one to w or file, flags untouched
// - skip result non-zero: next instruction runs, one instruction cycle
// - skip result zero: next instruction replaced by no-op, two cycles
// - or literal: w or 8-bit literal into w, z updated
// - load literal: literal into w, flags untouched
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

`define DATA_W        8
`define ADDR_W        7
`define OP_W          3
`define DEST_W_SEL    1'b0
`define DEST_F_SEL    1'b1
`define CLK_PERIOD_NS 40
`define INSTR_CYC_NS  160
`define CLKS_PER_CYC  (`INSTR_CYC_NS / `CLK_PERIOD_NS)
`define DIV_W         2
`define W_RST         8'h00
`define Z_RST         1'b0

`endif

// ===== include/exec_pkg.sv
// Purpose: types shared by the execution unit and its arithmetic stage
// Assumes: exec_consts.svh supplies the widths
// Notes:   opcode values are local to this unit, not the core's encoding
`include "exec_consts.svh"
package exec_pkg;

  typedef enum logic [`OP_W-1:0] {
    OP_NOP                    = 3'h0,
    OP_DECREMENT_FILE         = 3'h1,
    OP_INCREMENT_FILE         = 3'h2,
    OP_DECREMENT_SKIP_ZERO    = 3'h3,
    OP_INCREMENT_SKIP_ZERO    = 3'h4,
    OP_OR_LITERAL             = 3'h5,
    OP_LOAD_LITERAL           = 3'h6
  } op_t;

  typedef struct packed {
    logic                valid;
    op_t                 op;
    logic                dest;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  lit;
  } instr_t;

  typedef struct packed {
    logic [`DATA_W-1:0]  result;
    logic                to_w;
    logic                to_file;
    logic                z_upd;
    logic                z;
    logic                skip;
  } alu_out_t;

  typedef enum logic [1:0] {
    ST_EXEC = 2'h0,
    ST_SKIP = 2'h1
  } state_t;

endpackage : exec_pkg

// ===== rtl/exec_alu.sv
// Purpose: combinational result, destination, flag and skip decision
// Assumes: file operand is the addressed register read in the same cycle
// Notes:   no state; the top module registers everything it produces
`timescale 1ns/1ps
`include "exec_consts.svh"
module exec_alu
  import exec_pkg::*;
(
  input  instr_t              i_instr,
  input  logic [`DATA_W-1:0]  i_w,
  input  logic [`DATA_W-1:0]  i_file_rdata,
  output alu_out_t            o_alu
);

  // operation decode; default leaves every destination and flag alone
  always_comb begin
    o_alu         = '0;
    case (i_instr.op)
      OP_DECREMENT_FILE: begin
        o_alu.result  = i_file_rdata - 8'h01;
        o_alu.z_upd   = 1'b1;
      end
      OP_INCREMENT_FILE: begin
        o_alu.result  = i_file_rdata + 8'h01;
        o_alu.z_upd   = 1'b1;
      end
      OP_DECREMENT_SKIP_ZERO: begin
        o_alu.result  = i_file_rdata - 8'h01;
        o_alu.skip    = (o_alu.result == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO: begin
        o_alu.result  = i_file_rdata + 8'h01;
        o_alu.skip    = (o_alu.result == 8'h00);
      end
      OP_OR_LITERAL: begin
        o_alu.result  = i_w | i_instr.lit;
        o_alu.z_upd   = 1'b1;
        o_alu.to_w    = 1'b1;
      end
      OP_LOAD_LITERAL: begin
        o_alu.result  = i_instr.lit;
        o_alu.to_w    = 1'b1;
      end
      default: o_alu  = '0;
    endcase
    // file-register operations route by the destination bit
    if (i_instr.op inside {OP_DECREMENT_FILE, OP_INCREMENT_FILE,
                           OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO}) begin
      o_alu.to_w    = (i_instr.dest == `DEST_W_SEL);
      o_alu.to_file = (i_instr.dest == `DEST_F_SEL);
    end
    o_alu.z         = (o_alu.result == 8'h00);
  end

endmodule : exec_alu

// ===== rtl/inc_dec_literal_exec_unit.sv
// Purpose: executes increment/decrement, their skip forms and two literal ops
// Assumes: core presents one instruction per instruction cycle on i_instr,
//          with the addressed file register already on i_file_rdata
// Notes:   results land one clock after the instruction-cycle enable
`timescale 1ns/1ps
`include "exec_consts.svh"
module inc_dec_literal_exec_unit
  import exec_pkg::*;
(
  input  logic                i_ref_clk,
  input  logic                i_rst,
  input  instr_t              i_instr,
  input  logic [`DATA_W-1:0]  i_file_rdata,
  output logic [`DATA_W-1:0]  o_w,
  output logic                o_z,
  output logic                o_file_we,
  output logic [`ADDR_W-1:0]  o_file_addr,
  output logic [`DATA_W-1:0]  o_file_wdata,
  output logic                o_retire,
  output logic                o_nop_slot,
  output logic                o_cycle_strobe
);

  // registered state and next values
  logic [`DIV_W-1:0]   div_r;
  logic [`DIV_W-1:0]   div_nxt;
  logic                cyc_r;
  logic                cyc_nxt;
  state_t              state_r;
  state_t              state_nxt;
  logic [`DATA_W-1:0]  w_r;
  logic [`DATA_W-1:0]  w_nxt;
  logic                z_r;
  logic                z_nxt;
  logic                we_r;
  logic                we_nxt;
  logic [`ADDR_W-1:0]  addr_r;
  logic [`ADDR_W-1:0]  addr_nxt;
  logic [`DATA_W-1:0]  wdata_r;
  logic [`DATA_W-1:0]  wdata_nxt;
  logic                done_r;
  logic                done_nxt;
  logic                nop_r;
  logic                nop_nxt;
  logic                cycle_en;
  logic                take;
  alu_out_t            alu_o;

  // arithmetic and routing decision for the presented instruction
  exec_alu u_alu (
    .i_instr      (i_instr),
    .i_w          (w_r),
    .i_file_rdata (i_file_rdata),
    .o_alu        (alu_o)
  );

  // instruction-cycle divider: one enable pulse every four core clocks
  always_comb begin
    cycle_en = (div_r == `DIV_W'(`CLKS_PER_CYC - 1));
    div_nxt  = cycle_en ? '0 : div_r + `DIV_W'(1);
    cyc_nxt  = cycle_en;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= '0;
      cyc_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // an instruction is executed only outside a skip slot
  assign take = cycle_en && i_instr.valid && (state_r == ST_EXEC);

  // execution: the skip slot throws away whatever the core presents
  always_comb begin
    state_nxt = state_r;
    w_nxt     = w_r;
    z_nxt     = z_r;
    we_nxt    = 1'b0;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    done_nxt  = 1'b0;
    nop_nxt   = 1'b0;
    if (cycle_en) begin
      case (state_r)
        ST_EXEC: begin
          if (i_instr.valid) begin
            done_nxt = 1'b1;
            if (alu_o.to_w) begin
              w_nxt = alu_o.result;
            end
            if (alu_o.to_file) begin
              we_nxt    = 1'b1;
              addr_nxt  = i_instr.addr;
              wdata_nxt = alu_o.result;
            end
            if (alu_o.z_upd) begin
              z_nxt = alu_o.z;
            end
            // non-zero skip result keeps the pipe flowing next cycle
            state_nxt = alu_o.skip ? ST_SKIP : ST_EXEC;
          end
        end
        ST_SKIP: begin
          nop_nxt   = 1'b1;
          state_nxt = ST_EXEC;
        end
        default: state_nxt = ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_EXEC;
      w_r     <= `W_RST;
      z_r     <= `Z_RST;
      we_r    <= 1'b0;
      addr_r  <= '0;
      wdata_r <= '0;
      done_r  <= 1'b0;
      nop_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      w_r     <= w_nxt;
      z_r     <= z_nxt;
      we_r    <= we_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      done_r  <= done_nxt;
      nop_r   <= nop_nxt;
    end
  end

  // every output straight from a flop
  assign o_w            = w_r;
  assign o_z            = z_r;
  assign o_file_we      = we_r;
  assign o_file_addr    = addr_r;
  assign o_file_wdata   = wdata_r;
  assign o_retire       = done_r;
  assign o_nop_slot     = nop_r;
  assign o_cycle_strobe = cyc_r;

  // checks on the registered results, one clock after the taking edge
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  AST_DEC_FILE_WB: assert property (
    take && i_instr.op == OP_DECREMENT_FILE && i_instr.dest
    |=> o_file_we && o_file_wdata == $past(i_file_rdata) - 8'h01
        && o_file_addr == $past(i_instr.addr) && o_w == $past(w_r))
    else $error("decrement to file wrong");

  AST_INC_FILE_W: assert property (
    take && i_instr.op == OP_INCREMENT_FILE && !i_instr.dest
    |=> !o_file_we && o_w == $past(i_file_rdata) + 8'h01)
    else $error("increment to w wrong");

  AST_DEC_SKIP_FLAGS: assert property (
    take && i_instr.op == OP_DECREMENT_SKIP_ZERO
    |=> $stable(o_z) && (o_file_we || o_w == $past(i_file_rdata) - 8'h01))
    else $error("decrement-skip disturbed flags or result");

  AST_INC_SKIP_FLAGS: assert property (
    take && i_instr.op == OP_INCREMENT_SKIP_ZERO && i_instr.dest
    |=> $stable(o_z) && o_file_we && o_file_wdata == $past(i_file_rdata) + 8'h01)
    else $error("increment-skip disturbed flags or result");

  AST_SKIP_NONZERO: assert property (
    take && (i_instr.op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO})
    && alu_o.result != 8'h00
    |=> state_r == ST_EXEC ##4 !o_nop_slot)
    else $error("non-zero skip result stalled the next instruction");

  // the skip instruction itself retires first, then three quiet clocks, then the no-op slot
  AST_SKIP_ZERO: assert property (
    take && alu_o.skip
    |=> o_retire ##1 (state_r == ST_SKIP && !o_retire) [*3]
        ##1 (o_nop_slot && !o_retire && !o_file_we && $stable(o_w) && state_r == ST_EXEC))
    else $error("zero skip result did not replace next instruction");

  AST_NOP_SLOT_QUIET: assert property (
    state_r == ST_SKIP && cycle_en
    |=> o_nop_slot && !o_retire && !o_file_we && $stable(o_w) && $stable(o_z))
    else $error("discarded slot changed state");

  AST_SKIP_PASS_NEXT: assert property (
    take && (i_instr.op inside {OP_DECREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO})
    && !alu_o.skip ##4 i_instr.valid
    |=> o_retire && !o_nop_slot)
    else $error("instruction after non-zero skip not executed");

  // instruction cycle is exactly four core clocks long
  AST_CYCLE_STROBE: assert property (
    o_cycle_strobe
    |=> (!o_cycle_strobe) [*3] ##1 o_cycle_strobe)
    else $error("instruction cycle strobe spacing wrong");

  AST_OR_LITERAL: assert property (
    take && i_instr.op == OP_OR_LITERAL
    |=> o_w == ($past(w_r) | $past(i_instr.lit)) && !o_file_we)
    else $error("or literal wrong");

  AST_LOAD_LITERAL: assert property (
    take && i_instr.op == OP_LOAD_LITERAL
    |=> o_w == $past(i_instr.lit) && $stable(o_z))
    else $error("load literal wrong");

  AST_ZERO_FLAG: assert property (
    take && alu_o.z_upd
    |=> o_z == ($past(alu_o.result) == 8'h00))
    else $error("zero flag does not match result");

  COV_SKIP_TAKEN: cover property (take && alu_o.skip ##5 o_nop_slot);
  COV_SKIP_PASS: cover property (take && i_instr.op == OP_INCREMENT_SKIP_ZERO && !alu_o.skip);
  COV_Z_SET: cover property (take && i_instr.op == OP_DECREMENT_FILE && alu_o.z);
  COV_OR_LIT: cover property (take && i_instr.op == OP_OR_LITERAL);

endmodule : inc_dec_literal_exec_unit

// ===== verif/tb_top.sv
// Purpose: self-checking bench for the increment/decrement and literal unit
// Assumes: four clocks per instruction cycle, results one clock after enable
// Notes:   the bench drives the file read data itself and tracks w and z
`timescale 1ns/1ps
module tb_top;
  import exec_pkg::*;
  logic              i_ref_clk;
  logic              i_rst;
  instr_t            i_instr;
  logic [7:0]        i_file_rdata;
  logic [7:0]        o_w;
  logic              o_z;
  logic              o_file_we;
  logic [6:0]        o_file_addr;
  logic [7:0]        o_file_wdata;
  logic              o_retire;
  logic              o_nop_slot;
  logic              o_cycle_strobe;
  int                miscompares;
  int                checks_done;
  logic [7:0]        w_exp;
  logic              z_exp;

  inc_dec_literal_exec_unit u_dut (
    .i_ref_clk      (i_ref_clk),
    .i_rst          (i_rst),
    .i_instr        (i_instr),
    .i_file_rdata   (i_file_rdata),
    .o_w            (o_w),
    .o_z            (o_z),
    .o_file_we      (o_file_we),
    .o_file_addr    (o_file_addr),
    .o_file_wdata   (o_file_wdata),
    .o_retire       (o_retire),
    .o_nop_slot     (o_nop_slot),
    .o_cycle_strobe (o_cycle_strobe)
  );

  // clock and time-zero values
  initial i_ref_clk = 1'b0;
  always #20 i_ref_clk = ~i_ref_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic instr_t mk(input op_t op, input logic d, input logic [6:0] a,
                                input logic [7:0] k);
    mk = '{valid: 1'b1, op: op, dest: d, addr: a, lit: k};
  endfunction : mk

  // one instruction slot: present at the edge after a strobe, judge after the answer
  task automatic step(input instr_t ins, input logic [7:0] rd, input logic we,
                      input logic [7:0] wd, input logic ret, input logic nop);
    @(posedge i_ref_clk);
    i_instr <= ins;
    i_file_rdata <= rd;
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk({7'h00, o_cycle_strobe}, 8'h01);
    chk({7'h00, o_file_we}, {7'h00, we});
    chk({7'h00, o_retire}, {7'h00, ret});
    chk({7'h00, o_nop_slot}, {7'h00, nop});
    chk(o_w, w_exp);
    chk({7'h00, o_z}, {7'h00, z_exp});
    if (we) begin
      chk(o_file_wdata, wd);
      chk({1'b0, o_file_addr}, {1'b0, ins.addr});
    end
  endtask : step

  task automatic t_dec_inc;
    w_exp = 8'h00; z_exp = 1'b1;
    step(mk(OP_DECREMENT_FILE, 1'b0, 7'h7f, 8'h00), 8'h01, 0, 8'h00, 1, 0);
    z_exp = 1'b0;
    step(mk(OP_DECREMENT_FILE, 1'b1, 7'h00, 8'h00), 8'h00, 1, 8'hff, 1, 0);
    z_exp = 1'b1;
    step(mk(OP_INCREMENT_FILE, 1'b1, 7'h2a, 8'h00), 8'hff, 1, 8'h00, 1, 0);
    w_exp = 8'h80; z_exp = 1'b0;
    step(mk(OP_INCREMENT_FILE, 1'b0, 7'h11, 8'h00), 8'h7f, 0, 8'h00, 1, 0);
  endtask : t_dec_inc

  // zero skips discard the next slot; flags stay as the last flag-setting op left them
  task automatic t_skip;
    step(mk(OP_DECREMENT_SKIP_ZERO, 1'b1, 7'h05, 8'h00), 8'h01, 1, 8'h00, 1, 0);
    step(mk(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h55), 8'h00, 0, 8'h00, 0, 1);
    w_exp = 8'h00;
    step(mk(OP_INCREMENT_SKIP_ZERO, 1'b0, 7'h06, 8'h00), 8'hff, 0, 8'h00, 1, 0);
    step(mk(OP_INCREMENT_FILE, 1'b1, 7'h06, 8'h00), 8'h10, 0, 8'h00, 0, 1);
    step(mk(OP_INCREMENT_SKIP_ZERO, 1'b1, 7'h07, 8'h00), 8'h05, 1, 8'h06, 1, 0);
    w_exp = 8'h3c;
    step(mk(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h3c), 8'h00, 0, 8'h00, 1, 0);
    w_exp = 8'h02;
    step(mk(OP_DECREMENT_SKIP_ZERO, 1'b0, 7'h08, 8'h00), 8'h03, 0, 8'h00, 1, 0);
    // decrement of 0x01 into w gives zero, and this op does set the flag
    w_exp = 8'h00; z_exp = 1'b1;
    step(mk(OP_DECREMENT_FILE, 1'b0, 7'h08, 8'h00), 8'h01, 0, 8'h00, 1, 0);
  endtask : t_skip

  task automatic t_lit;
    instr_t idle;
    idle = mk(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h99);
    idle.valid = 1'b0;
    w_exp = 8'h00; z_exp = 1'b1;
    step(mk(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h00), 8'h00, 0, 8'h00, 1, 0);
    step(mk(OP_OR_LITERAL, 1'b0, 7'h00, 8'h00), 8'h00, 0, 8'h00, 1, 0);
    w_exp = 8'ha5; z_exp = 1'b0;
    step(mk(OP_OR_LITERAL, 1'b0, 7'h00, 8'ha5), 8'h00, 0, 8'h00, 1, 0);
    w_exp = 8'hff;
    step(mk(OP_OR_LITERAL, 1'b0, 7'h00, 8'h5a), 8'h00, 0, 8'h00, 1, 0);
    step(idle, 8'h00, 0, 8'h00, 0, 0);
    w_exp = 8'h00;
    step(mk(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h00), 8'h00, 0, 8'h00, 1, 0);
  endtask : t_lit

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // watchdog: the whole sequence needs well under a thousand clocks
  initial begin
    #(40 * 3000);
    miscompares++;
    complete_run();
  end

  initial begin
    miscompares = 0;
    checks_done = 0;
    i_rst = 1'b1;
    i_instr = '0;
    i_file_rdata = 8'h00;
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    // align to the instruction cycle by the strobe that follows each enable
    do begin
      @(posedge i_ref_clk);
      #1;
    end while (o_cycle_strobe !== 1'b1);
    t_dec_inc();
    t_skip();
    t_lit();
    complete_run();
  end
endmodule : tb_top
